// ===== hw/imdu_disp_if.sv
// carrier between the unit and its dispatch offset generator
`timescale 1ns/100ps
interface imdu_disp_if;
    import imdu_pkg::*;
    logic [2:0] sel;
    logic group_three;
    logic small_count_zero;
    logic condition_ok;
    imdu_mode_type mode;
    logic [2:0] param_idx;
    imdu_offset_type offset_n;
    modport gen (input sel, group_three, small_count_zero, condition_ok, mode, param_idx,
        output offset_n);
    modport user (output sel, group_three, small_count_zero, condition_ok, mode, param_idx,
        input offset_n);
endinterface : imdu_disp_if

// ===== hw/imdu_dispatch.sv
// dispatch offset generator
`timescale 1ns/100ps
`include "imdu_map.svh"
module imdu_dispatch (
    input wire logic i_clk,
    input wire logic i_arst_n,
    imdu_disp_if.gen d
);
    import imdu_pkg::*;
    logic [4:0] line;
    imdu_offset_type first_gen;
    imdu_offset_type pick;

    // one of five select lines
    always_comb begin
        line = 5'h00;
        if (d.sel < 3'h5) begin
            line[d.sel] = 1'b1;
        end
    end

    // priority chain of the first generator
    always_comb begin
        if (d.group_three && d.small_count_zero) begin
            first_gen = `IMDU_OFFSET_GP3;
        end else if (d.mode.repeat_mode) begin
            first_gen = `IMDU_OFFSET_REPEAT;
        end else if (d.mode.exec) begin
            first_gen = `IMDU_OFFSET_EXEC;
        end else if (d.mode.fb) begin
            first_gen = `IMDU_OFFSET_SECOND;
        end else begin
            first_gen = `IMDU_OFFSET_FETCH;
        end
    end

    always_comb begin
        pick = 3'h0;
        unique case (1'b1)
            line[0]: pick = first_gen;
            line[1]: pick = {2'h0, d.condition_ok};
            line[2]: pick = d.mode;
            line[3]: pick = d.param_idx;
            line[4]: pick = {1'b0, d.mode.repeat_mode, d.mode.exec};
            default: pick = 3'h0;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            d.offset_n <= 3'h7;
        end else begin
            d.offset_n <= ~pick;
        end
    end

    property p_first_chain;
        @(posedge i_clk) disable iff (!i_arst_n)
        (d.sel == 3'h0 && !(d.group_three && d.small_count_zero) && d.mode.repeat_mode)
            |=> (d.offset_n == 3'h3);
    endproperty
    a_first_chain: assert property (p_first_chain) else $error("repeat offset not 4");

    property p_gp3_wins;
        @(posedge i_clk) disable iff (!i_arst_n)
        (d.sel == 3'h0 && d.group_three && d.small_count_zero) |=> (d.offset_n == 3'h4);
    endproperty
    a_gp3_wins: assert property (p_gp3_wins) else $error("group three offset not 3");

    property p_no_line;
        @(posedge i_clk) disable iff (!i_arst_n)
        (d.sel > 3'h4) |=> (d.offset_n == 3'h7);
    endproperty
    a_no_line: assert property (p_no_line) else $error("unused select gave offset");
endmodule : imdu_dispatch

// ===== hw/imdu_map.svh
// constants of the instruction mode dispatch unit
// Functional notes
// - instruction latch loads while load strobe high
// - condition ok is bit 13 xor condition
// - three mode flops with fixed encoding
// - lowest mode bit picks fallback mode
// - repeat then one single execute then fallback
// - mode clear with execute clear forces fetch
// - count bit 18 low clears repeat under clear
// - execute flag clear clears execute flag
// - mode load strobe loads decoded mode
// - codes 0000 to 0011 decode as listed
// - codes 01xx 10xx 11xx set flags, fallback
// - push mode lines gated by instruction bit
// - three bit select picks one of five
// - first generator priority chain three four zero
// - dispatch offset is driven inverted
// - parameter index loads from given address
// - direction latch remembers increment or decrement
// - given address is default register address
// - instruction or parameter selects register address
// - register five forced for write only
// - direction out from latch on parameter read
// - done follows one of four one hot conditions
// - settled when all pipeline units wait
`ifndef IMDU_MAP_SVH
`define IMDU_MAP_SVH
`define IMDU_OFS_CTRL 32'h0000_0000
`define IMDU_OFS_STATUS 32'h0000_0004
`define IMDU_OFS_INSTR 32'h0000_0008
`define IMDU_CTRL_SOFT_CLEAR 0
`define IMDU_IR_COND_BIT 13
`define IMDU_IR_PUSH_BIT 4
`define IMDU_IR_CODE_MSB 14
`define IMDU_IR_CODE_LSB 17
`define IMDU_IR_ADDR_MSB 9
`define IMDU_IR_ADDR_LSB 12
`define IMDU_REG_FIVE 4'h5
`define IMDU_OFFSET_GP3 3'h3
`define IMDU_OFFSET_REPEAT 3'h4
`define IMDU_OFFSET_EXEC 3'h0
`define IMDU_OFFSET_SECOND 3'h1
`define IMDU_OFFSET_FETCH 3'h2
`define IMDU_INSTR_RESET 18'h0_0000
`define IMDU_MODE_RESET 3'h0
`define IMDU_RESP_OKAY 2'h0
`define IMDU_RESP_SLVERR 2'h2
`endif

// ===== hw/imdu_pkg.sv
// types of the instruction mode dispatch unit
package imdu_pkg;
    typedef struct packed {
        logic exec;
        logic repeat_mode;
        logic fb;
    } imdu_mode_type;
    typedef logic [2:0] imdu_offset_type;
    typedef logic [3:0] imdu_addr_type;
endpackage : imdu_pkg

// ===== hw/imdu_top.sv
// instruction mode dispatch unit with its register slave
`timescale 1ns/100ps
`include "imdu_map.svh"
module imdu_top #(
    parameter int UNITS = 4
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [17:0] i_memory_buffer,
    input wire logic i_instruction_load_strobe,
    input wire logic i_tested_condition,
    output logic o_condition_ok,
    output logic [17:0] o_instruction_latch,
    input wire logic i_mode_clear,
    input wire logic i_execute_flag_clear,
    input wire logic i_read_count_bit18,
    input wire logic i_mode_load_strobe,
    output imdu_pkg::imdu_mode_type o_mode,
    output imdu_pkg::imdu_mode_type o_push_mode_lines,
    input wire logic [2:0] i_dispatch_select_code,
    input wire logic i_group_three,
    input wire logic i_small_count_zero,
    output imdu_pkg::imdu_offset_type o_dispatch_offset_n,
    input wire logic [3:0] i_given_register_address,
    input wire logic i_parameter_load_strobe,
    input wire logic i_instr_addr_for_read,
    input wire logic i_instr_addr_for_write,
    input wire logic i_param_addr_for_read,
    input wire logic i_param_addr_for_write,
    input wire logic i_five_for_write,
    input wire logic i_address_direction_in,
    output logic o_address_direction_out,
    output imdu_pkg::imdu_addr_type o_read_addr,
    output imdu_pkg::imdu_addr_type o_write_addr,
    input wire logic i_buffer_free,
    input wire logic i_pause_request,
    input wire logic [UNITS-1:0] i_unit_idle,
    input wire logic i_buffer_free_done_enable,
    input wire logic i_pause_done_enable,
    input wire logic i_count_zero_done_enable,
    input wire logic i_settled_done_enable,
    output logic o_done,
    output logic o_settled,
    input wire logic [31:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [31:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready
);
    import imdu_pkg::*;

    logic [0:17] ir_reg;
    imdu_mode_type mode_reg;
    imdu_mode_type mode_next;
    logic exec_reg;
    logic repeat_mode_reg;
    logic fb_reg;
    logic [2:0] param_idx_reg;
    logic dir_latch_reg;
    logic soft_clear;
    logic clr_all;
    logic clr_exec;
    logic clr_repeat_mode;
    logic settled;
    logic aw_held_reg;
    logic w_held_reg;
    logic [31:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    imdu_disp_if disp ();

    function automatic imdu_mode_type mode_decode(input logic [3:0] code,
            input imdu_mode_type cur);
        imdu_mode_type m;
        m = cur;
        unique case (code)
            4'h0: m = cur;
            4'h1: m = '{exec: 1'b0, repeat_mode: 1'b0, fb: 1'b0};
            4'h2: m = '{exec: 1'b0, repeat_mode: 1'b0, fb: 1'b1};
            4'h3: m = '{exec: 1'b0, repeat_mode: 1'b0, fb: cur.fb};
            default: begin
                m.exec = code[3];
                m.repeat_mode = code[2];
                if (code[1:0] == 2'h1) begin
                    m.fb = 1'b0;
                end else if (code[1:0] == 2'h2) begin
                    m.fb = 1'b1;
                end
            end
        endcase
        return m;
    endfunction : mode_decode

    function automatic imdu_addr_type idx_addr(input logic [2:0] idx);
        return {1'b0, idx};
    endfunction : idx_addr

    // instruction latch
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ir_reg <= `IMDU_INSTR_RESET;
        end else if (i_instruction_load_strobe) begin
            ir_reg <= i_memory_buffer;
        end
    end

    assign o_instruction_latch = ir_reg;
    assign o_condition_ok = ir_reg[`IMDU_IR_COND_BIT] ^ i_tested_condition;

    // mode flops and their asynchronous clears
    assign clr_all = i_mode_clear && i_execute_flag_clear;
    assign clr_exec = i_execute_flag_clear;
    assign clr_repeat_mode = clr_all || (i_mode_clear && !i_read_count_bit18);
    assign mode_next = mode_decode(ir_reg[`IMDU_IR_CODE_MSB:`IMDU_IR_CODE_LSB],
        mode_reg);

    always_ff @(posedge i_clk or negedge i_arst_n or posedge clr_exec) begin
        if (!i_arst_n) begin
            exec_reg <= 1'b0;
        end else if (clr_exec) begin
            exec_reg <= 1'b0;
        end else if (soft_clear) begin
            exec_reg <= 1'b0;
        end else if (i_mode_load_strobe) begin
            exec_reg <= mode_next.exec;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n or posedge clr_repeat_mode) begin
        if (!i_arst_n) begin
            repeat_mode_reg <= 1'b0;
        end else if (clr_repeat_mode) begin
            repeat_mode_reg <= 1'b0;
        end else if (soft_clear) begin
            repeat_mode_reg <= 1'b0;
        end else if (i_mode_load_strobe) begin
            repeat_mode_reg <= mode_next.repeat_mode;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n or posedge clr_all) begin
        if (!i_arst_n) begin
            fb_reg <= 1'b0;
        end else if (clr_all) begin
            fb_reg <= 1'b0;
        end else if (soft_clear) begin
            fb_reg <= 1'b0;
        end else if (i_mode_load_strobe) begin
            fb_reg <= mode_next.fb;
        end
    end

    assign mode_reg = '{exec: exec_reg, repeat_mode: repeat_mode_reg, fb: fb_reg};
    assign o_mode = mode_reg;

    // push word mode lines
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_push_mode_lines <= `IMDU_MODE_RESET;
        end else if (ir_reg[`IMDU_IR_PUSH_BIT]) begin
            o_push_mode_lines <= mode_reg;
        end else begin
            o_push_mode_lines <= `IMDU_MODE_RESET;
        end
    end

    // dispatch offset generator
    assign disp.sel = i_dispatch_select_code;
    assign disp.group_three = i_group_three;
    assign disp.small_count_zero = i_small_count_zero;
    assign disp.condition_ok = o_condition_ok;
    assign disp.mode = mode_reg;
    assign disp.param_idx = param_idx_reg;
    assign o_dispatch_offset_n = disp.offset_n;

    imdu_dispatch u_dispatch (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .d(disp.gen)
    );

    // parameter index and direction latch
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            param_idx_reg <= 3'h0;
            dir_latch_reg <= 1'b0;
        end else if (i_parameter_load_strobe) begin
            param_idx_reg <= i_given_register_address[2:0];
            dir_latch_reg <= i_address_direction_in;
        end
    end

    // register address selection
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_read_addr <= 4'h0;
            o_write_addr <= 4'h0;
            o_address_direction_out <= 1'b0;
        end else begin
            if (i_instr_addr_for_read) begin
                o_read_addr <= ir_reg[`IMDU_IR_ADDR_MSB:`IMDU_IR_ADDR_LSB];
            end else if (i_param_addr_for_read) begin
                o_read_addr <= idx_addr(param_idx_reg);
            end else begin
                o_read_addr <= i_given_register_address;
            end
            if (i_five_for_write) begin
                o_write_addr <= `IMDU_REG_FIVE;
            end else if (i_instr_addr_for_write) begin
                o_write_addr <= ir_reg[`IMDU_IR_ADDR_MSB:`IMDU_IR_ADDR_LSB];
            end else if (i_param_addr_for_write) begin
                o_write_addr <= idx_addr(param_idx_reg);
            end else begin
                o_write_addr <= i_given_register_address;
            end
            o_address_direction_out <= i_param_addr_for_read ? dir_latch_reg :
                i_address_direction_in;
        end
    end

    // done selection
    assign settled = &i_unit_idle;
    assign o_settled = settled;
    always_comb begin
        unique case ({i_buffer_free_done_enable, i_pause_done_enable,
                i_count_zero_done_enable, i_settled_done_enable})
            4'h8: o_done = i_buffer_free;
            4'h4: o_done = i_pause_request;
            4'h2: o_done = i_small_count_zero || settled;
            4'h1: o_done = settled;
            default: o_done = 1'b0;
        endcase
    end

    // register bus write side
    assign o_awready = !aw_held_reg && !o_bvalid;
    assign o_wready = !w_held_reg && !o_bvalid;
    assign soft_clear = aw_held_reg && w_held_reg && !o_bvalid &&
        awaddr_reg == `IMDU_OFS_CTRL && wstrb_reg[0] &&
        wdata_reg[`IMDU_CTRL_SOFT_CLEAR];

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 32'h0000_0000;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            o_bvalid <= 1'b0;
            o_bresp <= `IMDU_RESP_OKAY;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= i_wdata;
                wstrb_reg <= i_wstrb;
            end
            if (aw_held_reg && w_held_reg && !o_bvalid) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= (awaddr_reg == `IMDU_OFS_CTRL) ? `IMDU_RESP_OKAY :
                    `IMDU_RESP_SLVERR;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // register bus read side
    assign o_arready = !o_rvalid;
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= `IMDU_RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            o_rresp <= `IMDU_RESP_OKAY;
            unique case (i_araddr)
                `IMDU_OFS_CTRL: o_rdata <= 32'h0000_0000;
                `IMDU_OFS_STATUS: o_rdata <= {23'h0, o_done, settled,
                    dir_latch_reg, param_idx_reg, mode_reg};
                `IMDU_OFS_INSTR: o_rdata <= {14'h0000, ir_reg};
                default: begin
                    o_rdata <= 32'h0000_0000;
                    o_rresp <= `IMDU_RESP_SLVERR;
                end
            endcase
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

    property p_ir_load;
        @(posedge i_clk) disable iff (!i_arst_n)
        i_instruction_load_strobe |=> (o_instruction_latch == $past(i_memory_buffer));
    endproperty
    a_ir_load: assert property (p_ir_load) else $error("instruction not captured");

    property p_cond;
        @(posedge i_clk) disable iff (!i_arst_n)
        o_condition_ok == (o_instruction_latch[4] ^ i_tested_condition);
    endproperty
    a_cond: assert property (p_cond) else $error("condition sense wrong");

    property p_clear_all;
        @(posedge i_clk) disable iff (!i_arst_n)
        (i_mode_clear && i_execute_flag_clear) |-> (o_mode == 3'h0);
    endproperty
    a_clear_all: assert property (p_clear_all) else $error("clear step left mode");

    property p_repeat_mode_drop;
        @(posedge i_clk) disable iff (!i_arst_n)
        (i_mode_clear && !i_read_count_bit18) |-> !o_mode.repeat_mode;
    endproperty
    a_repeat_mode_drop: assert property (p_repeat_mode_drop) else $error("repeat not dropped");

    property p_exec_clear;
        @(posedge i_clk) disable iff (!i_arst_n)
        i_execute_flag_clear |-> !o_mode.exec;
    endproperty
    a_exec_clear: assert property (p_exec_clear) else $error("execute flag kept");

    property p_load_repeat_mode;
        @(posedge i_clk) disable iff (!i_arst_n)
        (i_mode_load_strobe && !i_mode_clear && !i_execute_flag_clear && !soft_clear &&
            o_instruction_latch[3:2] == 2'h1 && o_instruction_latch[1:0] == 2'h2)
            |=> (o_mode == 3'h3 || i_execute_flag_clear || i_mode_clear);
    endproperty
    a_load_repeat_mode: assert property (p_load_repeat_mode) else $error("repeat load wrong");

    property p_five;
        @(posedge i_clk) disable iff (!i_arst_n)
        i_five_for_write |=> (o_write_addr == 4'h5);
    endproperty
    a_five: assert property (p_five) else $error("write address not five");

    property p_dir;
        @(posedge i_clk) disable iff (!i_arst_n)
        (!i_param_addr_for_read) |=> (o_address_direction_out == $past(i_address_direction_in));
    endproperty
    a_dir: assert property (p_dir) else $error("direction not copied");

    property p_done_settled;
        @(posedge i_clk) disable iff (!i_arst_n)
        ({i_buffer_free_done_enable, i_pause_done_enable, i_count_zero_done_enable,
            i_settled_done_enable} == 4'h1) |-> (o_done == (&i_unit_idle));
    endproperty
    a_done_settled: assert property (p_done_settled) else $error("done not settled");
endmodule : imdu_top

// ===== tb/imdu_top_test.sv
// self-checking bench of the instruction mode dispatch unit
`timescale 1ns/100ps
module imdu_top_test;
    import imdu_pkg::*;
    logic i_clk = 1'h0, i_arst_n = 1'h0, i_tested_condition = 1'h0, i_mode_clear = 1'h0;
    logic [17:0] i_memory_buffer = 18'h0, o_instruction_latch, ei = 18'h0;
    logic i_instruction_load_strobe = 1'h0, i_execute_flag_clear = 1'h0;
    logic i_read_count_bit18 = 1'h1, i_mode_load_strobe = 1'h0, i_parameter_load_strobe = 1'h0;
    logic i_group_three = 1'h0, i_small_count_zero = 1'h0, i_address_direction_in = 1'h0;
    logic [2:0] i_dispatch_select_code = 3'h0, eidx = 3'h0;
    logic [3:0] i_given_register_address = 4'h0, i_unit_idle = 4'h0, i_wstrb = 4'hF;
    logic i_instr_addr_for_read, i_instr_addr_for_write, i_param_addr_for_read;
    logic i_param_addr_for_write, i_five_for_write, i_buffer_free = 1'h0, i_pause_request = 1'h0;
    logic i_buffer_free_done_enable, i_pause_done_enable, i_count_zero_done_enable;
    logic i_settled_done_enable, edl = 1'h0, e_dir = 1'h0;
    logic [7:0] uword = 8'h0;
    logic [31:0] i_awaddr = 32'h0, i_wdata = 32'h0, i_araddr = 32'h0, o_rdata, r, q;
    logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h1, i_arvalid = 1'h0, i_rready = 1'h1;
    logic o_condition_ok, o_done, o_settled, o_address_direction_out;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0] o_bresp, o_rresp;
    imdu_mode_type o_mode, o_push_mode_lines, em = 3'h0, e_push = 3'h0;
    imdu_offset_type o_dispatch_offset_n, e_off = 3'h7;
    imdu_addr_type o_read_addr, o_write_addr, e_rd = 4'h0, e_wr = 4'h0;
    int n_fail = 0, total_checks = 0, seed = 35731;
    imdu_ucode_model ucm (
        .i_word(uword),
        .o_done_en({i_settled_done_enable, i_count_zero_done_enable,
            i_pause_done_enable, i_buffer_free_done_enable}),
        .o_sel({i_five_for_write, i_param_addr_for_write, i_param_addr_for_read,
            i_instr_addr_for_write, i_instr_addr_for_read})
    );
    imdu_top #(.UNITS(4)) dut (.*);
    always #4 i_clk = ~i_clk;
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task wrap_up;
        if (n_fail == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up
    function automatic imdu_mode_type dec(imdu_mode_type m, logic [3:0] c);
        imdu_mode_type n;
        n = m;
        if (c == 4'h1) n = 3'h0;
        else if (c == 4'h2) n = 3'h1;
        else if (c == 4'h3) n = {2'h0, m.fb};
        else if (c != 4'h0) begin
            n.exec = c[3];
            n.repeat_mode = c[2];
            if (c[1:0] == 2'h1) n.fb = 1'h0;
            else if (c[1:0] == 2'h2) n.fb = 1'h1;
        end
        return n;
    endfunction : dec
    function automatic imdu_mode_type clr(imdu_mode_type m);
        imdu_mode_type n;
        n = m;
        if (i_mode_clear && i_execute_flag_clear) n = 3'h0;
        if (i_mode_clear && !i_read_count_bit18) n.repeat_mode = 1'h0;
        if (i_execute_flag_clear) n.exec = 1'h0;
        return n;
    endfunction : clr
    function automatic imdu_offset_type disp(imdu_mode_type m);
        case (i_dispatch_select_code)
            3'h0: disp = (i_group_three && i_small_count_zero) ? 3'h3 :
                m.repeat_mode ? 3'h4 : m.exec ? 3'h0 : m.fb ? 3'h1 : 3'h2;
            3'h1: disp = {2'h0, ei[4] ^ i_tested_condition};
            3'h2: disp = m;
            3'h3: disp = eidx;
            3'h4: disp = {1'h0, m.repeat_mode, m.exec};
            default: disp = 3'h0;
        endcase
    endfunction : disp
    function automatic logic done_f();
        case (uword[2:0])
            3'h0: done_f = i_buffer_free;
            3'h1: done_f = i_pause_request;
            3'h2: done_f = i_small_count_zero | (&i_unit_idle);
            3'h3: done_f = &i_unit_idle;
            default: done_f = 1'h0;
        endcase
    endfunction : done_f
    task look;
        em = clr(em);
        check(o_mode, em);
        check(o_instruction_latch, ei);
        check(o_condition_ok, ei[4] ^ i_tested_condition);
        check(o_settled, &i_unit_idle);
        check(o_done, done_f());
        check(o_push_mode_lines, e_push);
        check(o_dispatch_offset_n, e_off);
        check(o_read_addr, e_rd);
        check(o_write_addr, e_wr);
        check(o_address_direction_out, e_dir);
    endtask : look
    task tick;
        @(negedge i_clk);
        look;
        @(posedge i_clk);
        e_off = ~disp(em);
        e_push = ei[13] ? em : 3'h0;
        e_rd = i_instr_addr_for_read ? ei[8:5] :
            i_param_addr_for_read ? {1'h0, eidx} : i_given_register_address;
        e_wr = i_five_for_write ? 4'h5 : i_instr_addr_for_write ? ei[8:5] :
            i_param_addr_for_write ? {1'h0, eidx} : i_given_register_address;
        e_dir = i_param_addr_for_read ? edl : i_address_direction_in;
        if (i_mode_load_strobe) em = clr(dec(em, ei[3:0]));
        if (i_instruction_load_strobe) ei = i_memory_buffer;
        if (i_parameter_load_strobe) begin
            eidx = i_given_register_address[2:0];
            edl = i_address_direction_in;
        end
    endtask : tick
    task quiet;
        i_mode_load_strobe <= 1'h0;
        i_parameter_load_strobe <= 1'h0;
        i_mode_clear <= 1'h0;
        i_execute_flag_clear <= 1'h0;
    endtask : quiet
    task axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] rs);
        logic b, ta, tw;
        b = 1'h0;
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'h1;
        i_wvalid <= 1'h1;
        for (int k = 0; k < 40 && !b; k++) begin
            @(negedge i_clk);
            ta = o_awready === 1'h1;
            tw = o_wready === 1'h1;
            b = o_bvalid === 1'h1;
            if (b) check(o_bresp, rs);
            @(posedge i_clk);
            if (ta) i_awvalid <= 1'h0;
            if (tw) i_wvalid <= 1'h0;
        end
        if (!b) begin
            n_fail++;
            wrap_up;
        end
    endtask : axi_wr
    task axi_rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] rs);
        logic v, t;
        v = 1'h0;
        i_araddr <= a;
        i_arvalid <= 1'h1;
        for (int k = 0; k < 40 && !v; k++) begin
            @(negedge i_clk);
            t = o_arready === 1'h1;
            v = o_rvalid === 1'h1;
            if (v) check(o_rdata, d);
            if (v) check(o_rresp, rs);
            @(posedge i_clk);
            if (t) i_arvalid <= 1'h0;
        end
        if (!v) begin
            n_fail++;
            wrap_up;
        end
    endtask : axi_rd
    initial begin
        @(negedge i_clk);
        look;
        @(posedge i_clk);
        @(posedge i_clk);
        i_arst_n <= 1'h1;
        repeat (400) begin
            tick;
            r = $random(seed);
            q = $random(seed);
            i_memory_buffer <= r[17:0];
            i_instruction_load_strobe <= r[18];
            i_mode_load_strobe <= r[19];
            i_parameter_load_strobe <= r[20];
            i_tested_condition <= r[21];
            i_group_three <= r[22];
            i_small_count_zero <= r[23];
            i_read_count_bit18 <= r[24];
            i_mode_clear <= r[26:25] == 2'h0;
            i_execute_flag_clear <= r[29:27] == 3'h0;
            i_address_direction_in <= r[30];
            i_buffer_free <= r[31];
            i_pause_request <= q[0];
            i_unit_idle <= (q[3:1] == 3'h7) ? 4'hF : q[7:4];
            i_given_register_address <= q[11:8];
            i_dispatch_select_code <= q[14:12];
            uword <= q[22:15];
        end
        tick;
        quiet;
        i_memory_buffer <= 18'h0_000E;
        i_instruction_load_strobe <= 1'h1;
        tick;
        i_instruction_load_strobe <= 1'h0;
        i_mode_load_strobe <= 1'h1;
        tick;
        i_mode_load_strobe <= 1'h0;
        tick;
        tick;
        axi_rd(32'h4, {23'h0, done_f(), &i_unit_idle, edl, eidx, em}, 2'h0);
        axi_rd(32'h8, {14'h0, ei}, 2'h0);
        axi_wr(32'h4, 32'hFFFF_FFFF, 2'h2);
        axi_rd(32'h40, 32'h0, 2'h2);
        axi_wr(32'h0, 32'h1, 2'h0);
        axi_rd(32'h4, {23'h0, done_f(), &i_unit_idle, edl, eidx, 3'h0}, 2'h0);
        wrap_up;
    end
endmodule : imdu_top_test

// ===== tb/imdu_ucode_model.sv
// microcode side model: done enables and register address selects
`timescale 1ns/100ps
module imdu_ucode_model (
    input wire logic [7:0] i_word,
    output logic [3:0] o_done_en,
    output logic [4:0] o_sel
);
    // done enables are one-hot or all low
    assign o_done_en = i_word[2] ? 4'h0 : 4'h1 << i_word[1:0];
    // selects: instr read, instr write, param read, param write, five for write
    assign o_sel = i_word[7:3];
endmodule : imdu_ucode_model
